//--- src/host_serial_flow_control.sv
// Host-facing serial port with flow control, AXI4-Lite registers
// Overview of operation
// R1: Bytes taken with command_select low are commands, high are payload.
// R2: Client drives link_present_n low while in range; server always low.
// R3: Client hearing no server for link_loss_timeout goes high and searches.
// R4: Host bytes held in a 256 byte buffer; bytes arriving when full lost.
// R5: CTS goes high once buffered count reaches flow_off_threshold.
// R6: With both levels at 1, CTS high on any data, low when empty.
// R7: Host may send while CTS high but risks overrunning the buffer.
// R8: With RTS handling off, bytes to host go out at once.
// R9: With RTS handling on, RTS high withholds output until RTS low.
// R10: Host should not hold RTS high long; full buffer loses data.
// R11: Test strap low at reset forces 9600 baud, 8-N-1.
// R12: Forced rate persists until reset with strap high.
// R13: Forced mode disables modem and parity modes, timeout fixed 0x40.
// R14: Host uses test strap only for recovery from unknown rates.
// R15: Host reads general inputs, writes general outputs; modem mode repurposes.
// R16: Local ADC read returns 10-bit analog_sense_in value.
// R17: Keep last valid-packet signal strength; return it on request.
// R18: Either reset input forces a soft reset; host uses only one.
// R19: Lines idle high; start bit is one bit time low.
// R20: Data bits follow LSB first, then a stop bit that is high.
// R21: Next start only after stop ends; both sides share fixed rate.
// R22: After CTS high, CTS drops once count falls to resume_level; the code drops it only when count is below resume_level.
// R23: Default rate is 57600 baud unless reprogrammed or forced.
// R24: Receiver finds start on falling edge, samples mid-bit.
`timescale 1ns/10ps
`include "host_serial_flow_control_defines.svh"
module host_serial_flow_control (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        processor_reset,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        host_rxd,
	output logic             host_txd,
	output logic             cts,
	input  wire logic        rts,
	input  wire logic        command_select,
	input  wire logic        test_strap,
	input  wire logic        general_input_0,
	input  wire logic        general_input_1,
	output logic             general_output_0,
	output logic             general_output_1,
	output logic             link_present_n,
	input  wire logic        server_heard,
	input  wire logic [9:0]  analog_sense_in,
	input  wire logic [7:0]  rssi_in,
	input  wire logic        rssi_valid
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [6:0] meta_r;
	logic [6:0] sync_r;
	logic       rx_d_r;
	logic       rst_n;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_r <= 7'h7f;
			sync_r <= 7'h7f;
		end
		else
		begin
			meta_r <= {processor_reset, general_input_1, general_input_0,
			           test_strap, command_select, rts, host_rxd};
			sync_r <= meta_r;
		end
	end
	wire rx_s   = sync_r[0];
	wire rts_s  = sync_r[1];
	wire csel_s = sync_r[2];
	wire strap_s = sync_r[3];
	// Soft reset from either input
	assign rst_n = aresetn & ~sync_r[6]; // see R18
	// ----------------------------------------
	// Configuration
	// ----------------------------------------
	host_serial_pkg::ctrl_s ctrl_r;
	logic [15:0] div_r;
	logic [7:0]  tmo_r;
	logic [8:0]  off_r;
	logic [8:0]  res_r;
	logic [31:0] link_tmo_r;
	logic [1:0]  gout_r;
	logic        forced_r;
	logic        cap_done_r;
	logic        modem_eff;
	logic [15:0] div_eff;
	logic [31:0] cfg_baud;
	// Strap caught once after reset release; later changes ignored
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			cap_done_r <= 1'b0;
			forced_r   <= 1'b0;
		end
		else if (!cap_done_r)
		begin
			cap_done_r <= 1'b1;
			forced_r   <= ~strap_s; // see R11 see R12
		end
	end
	assign div_eff   = forced_r ? `DIV_FORCED : div_r; // see R11 see R23
	assign modem_eff = ctrl_r.modem_mode & ~forced_r; // see R13
	assign cfg_baud  = {7'h0, ctrl_r.parity_mode & ~forced_r,
	                    forced_r ? `TMO_FORCED : tmo_r, div_eff}; // see R13
	// ----------------------------------------
	// Receiver and buffer
	// ----------------------------------------
	host_serial_pkg::line_state_e rx_st_r;
	host_serial_pkg::entry_s      mem_r [256];
	logic [15:0] rx_cnt_r;
	logic [2:0]  rx_bit_r;
	logic [7:0]  rx_sh_r;
	logic        rx_done;
	logic [7:0]  wr_ptr_r;
	logic [7:0]  rd_ptr_r;
	logic [8:0]  count_r;
	logic        ovf_r;
	logic        pop;
	logic        push;
	assign rx_done = (rx_st_r == host_serial_pkg::ST_STOP) && (rx_cnt_r == 16'h0) && rx_s;
	assign push    = rx_done && (count_r != `BUF_DEPTH); // see R4
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			rx_st_r  <= host_serial_pkg::ST_IDLE;
			rx_cnt_r <= 16'h0;
			rx_bit_r <= 3'h0;
			rx_sh_r  <= 8'h0;
			rx_d_r   <= 1'b1;
		end
		else
		begin
			rx_d_r <= rx_s;
			if (rx_cnt_r != 16'h0)
				rx_cnt_r <= rx_cnt_r - 16'h1;
			unique case (rx_st_r)
				host_serial_pkg::ST_IDLE:
					if (rx_d_r && !rx_s)
					begin
						rx_st_r  <= host_serial_pkg::ST_START; // see R24 see R19
						rx_cnt_r <= div_eff >> 1;
					end
				host_serial_pkg::ST_START:
					if (rx_cnt_r == 16'h0)
					begin
						rx_st_r  <= rx_s ? host_serial_pkg::ST_IDLE : host_serial_pkg::ST_DATA;
						// Zero count is a cycle too; reload one short to match the sender
						rx_cnt_r <= div_eff - 16'h1;
						rx_bit_r <= 3'h0;
					end
				host_serial_pkg::ST_DATA:
					if (rx_cnt_r == 16'h0)
					begin
						rx_sh_r  <= {rx_s, rx_sh_r[7:1]}; // see R20
						rx_bit_r <= rx_bit_r + 3'h1;
						rx_cnt_r <= div_eff - 16'h1;
						if (rx_bit_r == 3'h7)
							rx_st_r <= host_serial_pkg::ST_STOP;
					end
				host_serial_pkg::ST_STOP:
					if (rx_cnt_r == 16'h0)
						rx_st_r <= host_serial_pkg::ST_IDLE; // see R21
			endcase
		end
	end
	// Buffer storage needs no reset; count guards every read
	always_ff @(posedge aclk)
	begin
		if (push)
			mem_r[wr_ptr_r] <= '{cmd: ~csel_s, data: rx_sh_r}; // see R1
	end
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= 8'h0;
			rd_ptr_r <= 8'h0;
			count_r  <= 9'h0;
			ovf_r    <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 8'h1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 8'h1;
			if (push && !pop)
				count_r <= count_r + 9'h1;
			else if (pop && !push)
				count_r <= count_r - 9'h1;
			// Overflow set wins over the status read clear
			if (rx_done && !push)
				ovf_r <= 1'b1; // see R4
			else if (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == `OFF_STATUS)
				ovf_r <= 1'b0;
		end
	end
	// ----------------------------------------
	// Flow control and link indication
	// ----------------------------------------
	logic [31:0] link_cnt_r;
	logic        search_r;
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
			cts <= 1'b0;
		else if (count_r >= off_r)
			cts <= 1'b1; // see R5 see R6
		else if (count_r < res_r)
			cts <= 1'b0; // see R22 see R6
	end
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			link_cnt_r     <= 32'h0;
			link_present_n <= 1'b1;
			search_r       <= 1'b1;
		end
		else if (ctrl_r.server_mode || server_heard)
		begin
			link_cnt_r     <= 32'h0;
			link_present_n <= 1'b0; // see R2
			search_r       <= 1'b0;
		end
		else if (link_cnt_r >= link_tmo_r)
		begin
			link_present_n <= 1'b1; // see R3
			search_r       <= 1'b1;
		end
		else
			link_cnt_r <= link_cnt_r + 32'h1;
	end
	// ----------------------------------------
	// Transmitter toward the host
	// ----------------------------------------
	host_serial_pkg::line_state_e tx_st_r;
	logic [15:0] tx_cnt_r;
	logic [2:0]  tx_bit_r;
	logic [7:0]  tx_sh_r;
	logic [7:0]  hold_r;
	logic        hold_v_r;
	logic        tx_load;
	logic        wr_fire;
	logic [7:0]  wr_addr;
	logic [31:0] wdata_r;
	assign tx_load = (tx_st_r == host_serial_pkg::ST_IDLE) && hold_v_r
	                 && !(ctrl_r.rts_enable && rts_s); // see R8 see R9
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			tx_st_r  <= host_serial_pkg::ST_IDLE;
			tx_cnt_r <= 16'h0;
			tx_bit_r <= 3'h0;
			tx_sh_r  <= 8'h0;
			host_txd <= 1'b1;
		end
		else
		begin
			if (tx_cnt_r != 16'h0)
				tx_cnt_r <= tx_cnt_r - 16'h1;
			unique case (tx_st_r)
				host_serial_pkg::ST_IDLE:
					if (tx_load)
					begin
						tx_st_r  <= host_serial_pkg::ST_START;
						tx_sh_r  <= hold_r;
						host_txd <= 1'b0; // see R19
						tx_cnt_r <= div_eff - 16'h1;
					end
				host_serial_pkg::ST_START:
					if (tx_cnt_r == 16'h0)
					begin
						tx_st_r  <= host_serial_pkg::ST_DATA;
						host_txd <= tx_sh_r[0]; // see R20
						tx_sh_r  <= tx_sh_r >> 1;
						tx_bit_r <= 3'h0;
						tx_cnt_r <= div_eff - 16'h1;
					end
				host_serial_pkg::ST_DATA:
					if (tx_cnt_r == 16'h0)
					begin
						tx_cnt_r <= div_eff - 16'h1;
						tx_bit_r <= tx_bit_r + 3'h1;
						if (tx_bit_r == 3'h7)
						begin
							tx_st_r  <= host_serial_pkg::ST_STOP;
							host_txd <= 1'b1; // see R20
						end
						else
						begin
							host_txd <= tx_sh_r[0];
							tx_sh_r  <= tx_sh_r >> 1;
						end
					end
				host_serial_pkg::ST_STOP:
					if (tx_cnt_r == 16'h0)
						tx_st_r <= host_serial_pkg::ST_IDLE; // see R21
			endcase
		end
	end
	// One byte held; a write while it is full is dropped
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			hold_v_r <= 1'b0;
			hold_r   <= 8'h0;
		end
		else if (tx_load)
			hold_v_r <= 1'b0;
		else if (wr_fire && wr_addr == `OFF_TXDATA && !hold_v_r)
		begin
			hold_v_r <= 1'b1;
			hold_r   <= wdata_r[7:0];
		end
	end
	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic [7:0]  awaddr_r;
	logic [3:0]  wstrb_r;
	logic        aw_ok_r;
	logic        w_ok_r;
	logic        wr_map;
	logic        rd_map;
	logic [31:0] rd_word;
	logic [7:0]  rssi_r;
	assign wr_addr = awaddr_r;
	assign wr_fire = aw_ok_r && w_ok_r && !s_axi_bvalid;
	assign pop = s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == `OFF_RXDATA
	             && count_r != 9'h0;
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				merge[8*i +: 8] = nw[8*i +: 8];
	endfunction : merge
	always_comb
	begin
		wr_map = 1'b1;
		unique case (awaddr_r)
			`OFF_CTRL, `OFF_BAUD, `OFF_FLOW, `OFF_TXDATA, `OFF_GPIO, `OFF_LINK: ;
			default: wr_map = 1'b0;
		endcase
	end
	always_comb
	begin
		rd_map  = 1'b1;
		rd_word = 32'h0;
		unique case (s_axi_araddr[7:0])
			`OFF_CTRL:   rd_word = {28'h0, ctrl_r};
			`OFF_STATUS: rd_word = {7'h0, count_r, 10'h0, hold_v_r, ovf_r, forced_r,
			                        search_r, link_present_n, cts};
			`OFF_BAUD:   rd_word = cfg_baud;
			`OFF_FLOW:   rd_word = {7'h0, res_r, 7'h0, off_r};
			// Empty reads give zero, never stale storage
			`OFF_RXDATA: rd_word = (count_r != 9'h0) ? {22'h0, 1'b1, mem_r[rd_ptr_r]}
			                                         : 32'h0; // see R1
			`OFF_TXDATA: rd_word = {31'h0, hold_v_r};
			`OFF_GPIO:   rd_word = {28'h0, sync_r[5:4], gout_r}; // see R15
			`OFF_ADC:    rd_word = {22'h0, analog_sense_in}; // see R16
			`OFF_RSSI:   rd_word = {24'h0, rssi_r}; // see R17
			`OFF_LINK:   rd_word = link_tmo_r;
			default:     rd_map = 1'b0;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			aw_ok_r       <= 1'b0;
			w_ok_r        <= 1'b0;
			awaddr_r      <= 8'h0;
			wdata_r       <= 32'h0;
			wstrb_r       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_ok_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_ok_r && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_ok_r  <= 1'b1;
				awaddr_r <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_ok_r  <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_ok_r      <= 1'b0;
				w_ok_r       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			ctrl_r     <= '0;
			div_r      <= `DIV_DEFAULT; // see R23
			tmo_r      <= `TMO_RST;
			off_r      <= `OFF_LVL_RST;
			res_r      <= `RES_LVL_RST;
			link_tmo_r <= `LINK_TMO_RST;
			gout_r     <= 2'h0;
		end
		else if (wr_fire)
		begin
			unique case (awaddr_r)
				`OFF_CTRL: ctrl_r <= 4'(merge({28'h0, ctrl_r}, wdata_r, wstrb_r));
				`OFF_BAUD: {tmo_r, div_r} <= 24'(merge({8'h0, tmo_r, div_r}, wdata_r, wstrb_r));
				`OFF_FLOW:
				begin
					if (wstrb_r[0])
						off_r[7:0] <= wdata_r[7:0];
					if (wstrb_r[1])
						off_r[8] <= wdata_r[8];
					if (wstrb_r[2])
						res_r[7:0] <= wdata_r[23:16];
					if (wstrb_r[3])
						res_r[8] <= wdata_r[24];
				end
				`OFF_GPIO: if (wstrb_r[0]) gout_r <= wdata_r[1:0]; // see R15
				`OFF_LINK: link_tmo_r <= merge(link_tmo_r, wdata_r, wstrb_r);
				default: ;
			endcase
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `RESP_OKAY;
			rssi_r        <= 8'h0;
			general_output_0 <= 1'b0;
			general_output_1 <= 1'b0;
		end
		else
		begin
			if (rssi_valid)
				rssi_r <= rssi_in; // see R17
			// Modem mode: pins show pending output and link state
			general_output_0 <= modem_eff ? hold_v_r : gout_r[0]; // see R15
			general_output_1 <= modem_eff ? ~link_present_n : gout_r[1];
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!rst_n);
	chk_cts_on_level: assert property ((count_r >= off_r) |=> cts) // see R5
		else $error("cts not raised at threshold");
	chk_cts_resume: assert property ((count_r < res_r && count_r < off_r) |=> !cts) // see R22
		else $error("cts not dropped at resume level");
	chk_full_drop: assert property ((count_r == `BUF_DEPTH && !pop) |=> count_r == `BUF_DEPTH) // see R4
		else $error("full buffer changed without pop");
	chk_rts_withhold: assert property ((tx_st_r == host_serial_pkg::ST_IDLE && ctrl_r.rts_enable
		&& rts_s) |=> tx_st_r == host_serial_pkg::ST_IDLE && host_txd) // see R9
		else $error("byte sent while rts high");
	chk_start_low: assert property ((tx_st_r == host_serial_pkg::ST_IDLE && tx_load)
		|=> !host_txd [*2]) // see R19
		else $error("start bit not low");
	chk_stop_high: assert property ((tx_st_r == host_serial_pkg::ST_STOP) |-> host_txd) // see R20
		else $error("stop bit not high");
	chk_server_link: assert property (ctrl_r.server_mode |=> !link_present_n) // see R2
		else $error("server not showing link");
	chk_link_loss: assert property ((!ctrl_r.server_mode && !server_heard
		&& link_cnt_r >= link_tmo_r) |=> link_present_n && search_r) // see R3
		else $error("link loss not reported");
	chk_strap_hold: assert property (cap_done_r |=> $stable(forced_r)) // see R12
		else $error("forced rate changed during run");
	chk_forced_cfg: assert property (forced_r |-> !modem_eff && cfg_baud[23:16] == `TMO_FORCED
		&& div_eff == `DIV_FORCED) // see R13
		else $error("forced mode settings wrong");
endmodule : host_serial_flow_control

//--- src/host_serial_flow_control_defines.svh
// Offsets, reset values and timing counts for the host serial block
`ifndef HOST_SERIAL_FLOW_CONTROL_DEFINES_SVH
`define HOST_SERIAL_FLOW_CONTROL_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CTRL     8'h00
`define OFF_STATUS   8'h04
`define OFF_BAUD     8'h08
`define OFF_FLOW     8'h0c
`define OFF_RXDATA   8'h10
`define OFF_TXDATA   8'h14
`define OFF_GPIO     8'h18
`define OFF_ADC      8'h1c
`define OFF_RSSI     8'h20
`define OFF_LINK     8'h24
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ       25000000
`define BAUD_DEFAULT 57600
`define BAUD_FORCED  9600
`define DIV_DEFAULT  16'((`CLK_HZ) / (`BAUD_DEFAULT))
`define DIV_FORCED   16'((`CLK_HZ) / (`BAUD_FORCED))
// ----------------------------------------
// Reset values and fixed settings
// ----------------------------------------
`define BUF_DEPTH    9'h100
`define TMO_RST      8'h02
`define TMO_FORCED   8'h40
`define OFF_LVL_RST  9'h0c0
`define RES_LVL_RST  9'h040
`define LINK_TMO_RST 32'h000f_4240
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

//--- src/host_serial_pkg.sv
// Types shared by the host serial block
package host_serial_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} line_state_e;
	typedef struct packed {
		logic parity_mode;
		logic modem_mode;
		logic server_mode;
		logic rts_enable;
	} ctrl_s;
	typedef struct packed {
		logic       cmd;
		logic [7:0] data;
	} entry_s;
endpackage : host_serial_pkg

//--- verification/host_uart_model.sv
// Host-side serial partner that sends and receives 8-N-1 characters
`timescale 1ns/10ps
module host_uart_model (
	input  wire logic        aclk,
	input  wire logic [15:0] div,
	input  wire logic        host_txd,
	output logic             host_rxd,
	output logic             rts
);
	logic [7:0] rx_q[$];
	int         frame_errs;
	initial
	begin
		host_rxd   = 1'b1;
		rts        = 1'b0;
		frame_errs = 0;
	end
	// Sends even while flow is off; overrun is the host's risk
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge aclk);
			host_rxd <= frame[i];
			repeat (div - 16'h0001) @(posedge aclk);
		end
	endtask : send_byte
	// Caller keeps the hold short so the device buffer never fills
	task automatic set_rts(input logic v);
		@(posedge aclk);
		rts <= v;
	endtask : set_rts
	// Mid-bit sampling; stop must be high before the next start
	always
	begin
		logic [7:0] b;
		@(negedge host_txd);
		repeat (div >> 1) @(posedge aclk);
		if (host_txd !== 1'b0)
			frame_errs++;
		for (int i = 0; i < 8; i++)
		begin
			repeat (div) @(posedge aclk);
			b[i] = host_txd;
		end
		repeat (div) @(posedge aclk);
		if (host_txd !== 1'b1)
			frame_errs++;
		rx_q.push_back(b);
	end
endmodule : host_uart_model

//--- verification/host_serial_flow_control_tb_top.sv
// Self-checking bench for the host serial block
`timescale 1ns/10ps
`include "host_serial_flow_control_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module host_serial_flow_control_tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        aclk, aresetn, processor_reset, test_strap, command_select;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        host_rxd, host_txd, cts, rts, link_present_n, server_heard, rssi_valid;
	logic        general_input_0, general_input_1, general_output_0, general_output_1;
	logic [9:0]  analog_sense_in;
	logic [7:0]  rssi_in;
	logic [15:0] div;
	int          num_errors, n_checks, cyc;

	host_serial_flow_control host_serial_flow_control_inst (.aclk, .aresetn, .processor_reset,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .host_rxd, .host_txd, .cts, .rts, .command_select,
		.test_strap, .general_input_0, .general_input_1, .general_output_0,
		.general_output_1, .link_present_n, .server_heard, .analog_sense_in, .rssi_in,
		.rssi_valid);
	host_uart_model host_uart_model_inst (.aclk, .div, .host_txd, .host_rxd, .rts);

	initial
	begin
		aclk = 1'b0; aresetn = 1'b0; processor_reset = 1'b0; test_strap = 1'b1;
		command_select = 1'b1; s_axi_awaddr = '0; s_axi_wdata = '0; s_axi_araddr = '0;
		s_axi_wstrb = 4'hf; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; server_heard = 1'b0; rssi_valid = 1'b0;
		general_input_0 = 1'b0; general_input_1 = 1'b0; analog_sense_in = '0;
		rssi_in = '0; div = `DIV_DEFAULT; num_errors = 0; n_checks = 0; cyc = 0;
	end
	always #20 aclk = ~aclk;
	// Long serial runs dominate; ceiling leaves ample margin
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			num_errors++;
			finish_test();
		end
	end
	// ----------------------------------------
	// Bus and line tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok  = 1'b0;
		@(posedge aclk);
		s_axi_awaddr  <= {24'h0, a};
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr  <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready  <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d   = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		axi_rd(a, rd);
		`CHK(rd, e)
	endtask : rd_chk
	task automatic do_reset(input logic s);
		@(posedge aclk);
		aresetn    <= 1'b0;
		test_strap <= s;
		tick(6);
		aresetn <= 1'b1;
		tick(4);
		test_strap <= 1'b1;
		div = `DIV_DEFAULT;
	endtask : do_reset
	task automatic send(input logic [7:0] b, input logic cs);
		@(posedge aclk);
		command_select <= cs;
		host_uart_model_inst.send_byte(b);
		tick(6);
	endtask : send
	task automatic set_div(input logic [15:0] d);
		axi_wr(`OFF_BAUD, {8'h00, `TMO_RST, d});
		div = d;
	endtask : set_div
	task automatic wait_rx();
		for (int k = 0; k < 400 && host_uart_model_inst.rx_q.size() == 0; k++)
			@(posedge aclk);
	endtask : wait_rx
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_defaults();
		`CHK(host_txd, 1'b1)
		`CHK(cts, 1'b0)
		rd_chk(`OFF_BAUD, {8'h00, `TMO_RST, `DIV_DEFAULT});
		axi_rd(8'h30, rd);
		`CHK(rsp, `RESP_SLVERR)
		axi_wr(8'h30, 32'h0);
		`CHK(rsp, `RESP_SLVERR)
	endtask : t_defaults
	// Strap low only to recover an unknown rate
	task automatic t_forced();
		do_reset(1'b0);
		div = `DIV_FORCED;
		rd_chk(`OFF_BAUD, {8'h00, `TMO_FORCED, `DIV_FORCED});
		axi_wr(`OFF_CTRL, 32'hc);
		axi_wr(`OFF_GPIO, 32'h1);
		tick(2);
		`CHK(general_output_0, 1'b1)
		axi_rd(`OFF_BAUD, rd);
		`CHK(rd[24], 1'b0)
		send(8'h96, 1'b1);
		rd_chk(`OFF_RXDATA, 32'h296);
		axi_rd(`OFF_STATUS, rd);
		`CHK(rd[3], 1'b1)
		do_reset(1'b1);
		axi_rd(`OFF_STATUS, rd);
		`CHK(rd[3], 1'b0)
		@(posedge aclk);
		test_strap <= 1'b0;
		tick(6);
		axi_rd(`OFF_STATUS, rd);
		`CHK(rd[3], 1'b0)
		test_strap <= 1'b1;
	endtask : t_forced
	task automatic t_rx();
		set_div(16'h0008);
		send(8'ha5, 1'b0);
		send(8'h3c, 1'b1);
		rd_chk(`OFF_RXDATA, 32'h3a5);
		rd_chk(`OFF_RXDATA, 32'h23c);
		rd_chk(`OFF_RXDATA, 32'h0);
	endtask : t_rx
	task automatic t_cts();
		axi_wr(`OFF_FLOW, 32'h0002_0003);
		send(8'h01, 1'b1);
		send(8'h02, 1'b1);
		`CHK(cts, 1'b0)
		send(8'h03, 1'b1);
		`CHK(cts, 1'b1)
		for (int i = 0; i < 3; i++)
		begin
			axi_rd(`OFF_RXDATA, rd);
			tick(2);
			`CHK(cts, (i == 0) ? 1'b1 : 1'b0)
		end
		axi_wr(`OFF_FLOW, 32'h0001_0001);
		send(8'h04, 1'b1);
		`CHK(cts, 1'b1)
		axi_rd(`OFF_RXDATA, rd);
		tick(2);
		`CHK(cts, 1'b0)
	endtask : t_cts
	task automatic t_overflow();
		axi_wr(`OFF_FLOW, 32'h0040_00c0);
		for (int i = 0; i < 257; i++)
			send(i[7:0], 1'b1);
		axi_rd(`OFF_STATUS, rd);
		`CHK(rd[24:16], 9'h100)
		`CHK(rd[4], 1'b1)
		`CHK(cts, 1'b1)
		axi_rd(`OFF_STATUS, rd);
		`CHK(rd[4], 1'b0)
		for (int i = 0; i < 256; i++)
			rd_chk(`OFF_RXDATA, {22'h0, 2'b10, i[7:0]});
		rd_chk(`OFF_RXDATA, 32'h0);
		tick(2);
		`CHK(cts, 1'b0)
	endtask : t_overflow
	task automatic t_tx();
		int low;
		low = 0;
		host_uart_model_inst.set_rts(1'b1);
		axi_wr(`OFF_TXDATA, 32'h5a);
		wait_rx();
		`CHK(host_uart_model_inst.rx_q.pop_front(), 8'h5a)
		axi_wr(`OFF_CTRL, 32'h1);
		axi_wr(`OFF_TXDATA, 32'hc3);
		for (int k = 0; k < 200; k++)
		begin
			@(posedge aclk);
			if (host_txd !== 1'b1)
				low++;
		end
		`CHK(low, 0)
		axi_rd(`OFF_STATUS, rd);
		`CHK(rd[5], 1'b1)
		host_uart_model_inst.set_rts(1'b0);
		wait_rx();
		`CHK(host_uart_model_inst.rx_q.pop_front(), 8'hc3)
		`CHK(host_uart_model_inst.frame_errs, 0)
	endtask : t_tx
	task automatic t_misc();
		axi_wr(`OFF_CTRL, 32'h0);
		axi_wr(`OFF_GPIO, 32'h2);
		@(posedge aclk);
		general_input_0 <= 1'b1;
		analog_sense_in <= 10'h2c5;
		rssi_in         <= 8'h77;
		rssi_valid      <= 1'b1;
		@(posedge aclk);
		rssi_valid <= 1'b0;
		rssi_in    <= 8'h11;
		tick(3);
		`CHK({general_output_1, general_output_0}, 2'b10)
		rd_chk(`OFF_GPIO, 32'h6);
		rd_chk(`OFF_ADC, 32'h2c5);
		rd_chk(`OFF_RSSI, 32'h77);
		axi_wr(`OFF_LINK, 32'd20);
		@(posedge aclk);
		server_heard <= 1'b1;
		@(posedge aclk);
		server_heard <= 1'b0;
		tick(10);
		`CHK(link_present_n, 1'b0)
		tick(30);
		`CHK(link_present_n, 1'b1)
		axi_rd(`OFF_STATUS, rd);
		`CHK(rd[2], 1'b1)
		axi_wr(`OFF_CTRL, 32'h2);
		tick(2);
		`CHK(link_present_n, 1'b0)
		axi_wr(`OFF_GPIO, 32'h1);
		axi_wr(`OFF_CTRL, 32'h6);
		tick(2);
		`CHK({general_output_1, general_output_0}, 2'b10)
	endtask : t_misc
	task automatic t_soft_reset();
		@(posedge aclk);
		processor_reset <= 1'b1;
		tick(2);
		processor_reset <= 1'b0;
		tick(6);
		`CHK(general_output_1, 1'b0)
		rd_chk(`OFF_BAUD, {8'h00, `TMO_RST, `DIV_DEFAULT});
	endtask : t_soft_reset
	task automatic finish_test();
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		do_reset(1'b1);
		t_defaults();
		t_forced();
		t_rx();
		t_cts();
		t_overflow();
		t_tx();
		t_misc();
		t_soft_reset();
		finish_test();
	end
endmodule : host_serial_flow_control_tb_top
